// >>> design/gmaf_addr_path.sv
`timescale 1ns/1ns
`include "gmaf_defs.svh"
module gmaf_addr_path #(
	parameter int AW = 32,
	parameter int PA_W = 39,
	parameter int IDX_W = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [AW-1:0] in_addr,
	input wire logic in_write,
	input wire logic in_cpu,
	input wire logic in_surf_tiled,
	input wire logic [AW-1:0] gm_base,
	input wire logic [AW-1:0] fence_lo,
	input wire logic [AW-1:0] fence_hi,
	input wire logic [2:0] fence_pitch_log2,
	input wire logic pte_we,
	input wire logic [IDX_W-1:0] pte_idx,
	input wire logic [PA_W-`GMAF_PAGE_LOG2-1:0] pte_frame,
	input wire logic pte_cacheable,
	output logic out_valid,
	input wire logic out_ready,
	output logic [PA_W-1:0] out_addr,
	output logic out_write,
	output logic out_snoop,
	output logic out_fault
);

	localparam int FR_W = PA_W - `GMAF_PAGE_LOG2;

	logic [FR_W-1:0] pte_frames [2**IDX_W];
	logic [2**IDX_W-1:0] pte_cache;
	logic [2**IDX_W-1:0] pte_valid;
	logic [AW-1:0] gm_addr;
	logic tiled;
	logic [AW-1:0] log_addr;
	logic [IDX_W-1:0] idx;

	// ---------------------------------------------
	// Normalise, tile, then translate
	// ---------------------------------------------
	assign gm_addr = in_addr - gm_base;
	assign tiled = in_surf_tiled || (gm_addr >= fence_lo && gm_addr <= fence_hi);

	always_comb begin
		logic [AW-1:0] rit;
		logic [AW-1:0] tcol;
		logic [AW-1:0] trow;
		rit = (gm_addr >> (`GMAF_TROW_LOG2 + fence_pitch_log2)) & AW'(7);
		tcol = (gm_addr >> `GMAF_TROW_LOG2) & ((AW'(1) << fence_pitch_log2) - AW'(1));
		trow = gm_addr >> (`GMAF_PAGE_LOG2 + fence_pitch_log2);
		if (tiled) begin
			log_addr = (((trow << fence_pitch_log2) | tcol) << `GMAF_PAGE_LOG2)
				| (rit << `GMAF_TROW_LOG2) | (gm_addr & AW'(511));
		end else begin
			log_addr = gm_addr;
		end
	end

	assign idx = log_addr[`GMAF_PAGE_LOG2 +: IDX_W];
	assign in_ready = !out_valid || out_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pte_valid <= '0;
			pte_cache <= '0;
		end else if (pte_we) begin
			pte_valid[pte_idx] <= 1'b1;
			pte_cache[pte_idx] <= pte_cacheable;
		end
	end

	always_ff @(posedge clk) begin
		if (pte_we) begin
			pte_frames[pte_idx] <= pte_frame;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_addr <= '0;
			out_write <= 1'b0;
			out_snoop <= 1'b0;
			out_fault <= 1'b0;
		end else if (in_ready) begin
			out_valid <= in_valid;
			out_addr <= {pte_frames[idx], log_addr[`GMAF_PAGE_LOG2-1:0]};
			out_write <= in_write;
			out_snoop <= in_cpu && pte_cache[idx];
			out_fault <= in_valid && !pte_valid[idx];
		end
	end

	a_cpu_snooped: assert property (@(posedge clk) disable iff (!rst_n)
		in_valid && in_ready && in_cpu && pte_cache[idx] && !pte_we |=> out_snoop)
		else $error("cacheable cpu access not snooped");

endmodule

// >>> design/gmaf_defs.svh
`ifndef GMAF_DEFS_SVH
`define GMAF_DEFS_SVH

// ---------------------------------------------
// Alias window onto the memory controller space
// ---------------------------------------------
`define GMAF_ALIAS_FIRST 24'h140000
`define GMAF_ALIAS_LAST 24'h147FFF
`define GMAF_ALIAS_OFS_W 15

// ---------------------------------------------
// Arbitration
// ---------------------------------------------
`define GMAF_LEVELS 4
`define GMAF_MAX_TOP 8'h10
`define GMAF_MAX_STEP 8'h04

// ---------------------------------------------
// Tiling and translation
// ---------------------------------------------
`define GMAF_PAGE_LOG2 12
`define GMAF_TROW_LOG2 9
`define GMAF_TROWS_LOG2 3

`endif

// >>> design/gmaf_pkg.sv
package gmaf_pkg;

	typedef logic [1:0] gmaf_level_t;

	typedef enum logic [1:0] {
		SRC_CPU = 2'h0,
		SRC_LRI = 2'h1,
		SRC_SRM = 2'h2,
		SRC_PEER = 2'h3
	} gmaf_src_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_DWORD = 2'h2,
		SZ_QWORD = 2'h3
	} gmaf_size_t;

	// Gray order along idle, run, end
	typedef enum logic [1:0] {
		GR_IDLE = 2'h0,
		GR_RUN = 2'h1,
		GR_END = 2'h3
	} gmaf_grace_t;

endpackage

// >>> design/gmaf_req_counter.sv
`timescale 1ns/1ns
module gmaf_req_counter #(
	parameter int CNT_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [CNT_W-1:0] max_cnt,
	input wire logic charge,
	input wire logic restart,
	output logic [CNT_W-1:0] used,
	output logic exhausted
);

	// ---------------------------------------------
	// Per-period access count
	// ---------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			used <= '0;
		end else if (restart) begin
			used <= charge ? CNT_W'(1) : '0;
		end else if (charge && !exhausted) begin
			used <= used + CNT_W'(1);
		end
	end

	assign exhausted = (used >= max_cnt);

	a_restart_clears: assert property (@(posedge clk) disable iff (!rst_n)
		restart |=> used <= CNT_W'(1)) else $error("count not cleared at restart");

	a_charge_counts: assert property (@(posedge clk) disable iff (!rst_n)
		charge && !restart && !exhausted |=> used == $past(used) + CNT_W'(1))
		else $error("granted access not charged");

endmodule

// >>> design/gmaf_top.sv
// Behaviour
// - Four priority levels; each requester's level comes from its configuration.
// - Every grant below the maximum is charged to the requester's own count.
// - A requester at its maximum drops below all levels, served in pipeline order.
// - When all counts are spent the grace period ends and counts restart.
// - Maximum counts are writable; defaults fall off along the pipeline order.
// - Window 140000h..147FFFh forwards aligned word, dword, qword accesses.
// - Forwarded accesses keep size and direction unchanged for the target.
// - Alias serves processor accesses only; command-stream loads are dropped.
// - Command-stream stores reading the alias get all zeros.
// - Alias is off while function memory space is disabled or power saving.
// - Graphics registers are reachable through function 0 and function 1.
// - External addresses are first made zero based.
// - Addresses in a fence or marked by surface are tiled, else linear.
// - Logical address is translated through the table to a physical one.
// - Processor accesses go out with snoop set for cacheable pages.
// - Peers may only write memory; peer register accesses are refused.
`timescale 1ns/1ns
`include "gmaf_defs.svh"
module gmaf_top #(
	parameter int N_REQ = 4,
	parameter int CNT_W = 8,
	parameter int AW = 32,
	parameter int PA_W = 39,
	parameter int IDX_W = 6
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [N_REQ-1:0] REQ,
	input wire logic [N_REQ*AW-1:0] REQ_ADDR,
	input wire logic [N_REQ-1:0] REQ_WRITE,
	input wire logic [N_REQ-1:0] REQ_TILED,
	input wire logic [N_REQ*2-1:0] REQ_LEVEL,
	output logic [N_REQ-1:0] GNT,
	input wire logic CFG_WE,
	input wire logic [$clog2(N_REQ)-1:0] CFG_IDX,
	input wire logic [CNT_W-1:0] CFG_MAX,
	output logic [N_REQ-1:0] DEMOTED,
	input wire logic HOST_VALID,
	output logic HOST_READY,
	input wire logic [AW-1:0] HOST_ADDR,
	input wire logic HOST_WRITE,
	input wire logic HOST_PEER,
	output logic HOST_ERR,
	input wire logic [AW-1:0] GM_BASE,
	input wire logic [AW-1:0] FENCE_LO,
	input wire logic [AW-1:0] FENCE_HI,
	input wire logic [2:0] FENCE_PITCH_LOG2,
	input wire logic PTE_WE,
	input wire logic [IDX_W-1:0] PTE_IDX,
	input wire logic [PA_W-`GMAF_PAGE_LOG2-1:0] PTE_FRAME,
	input wire logic PTE_CACHEABLE,
	output logic RING_VALID,
	input wire logic RING_READY,
	output logic [PA_W-1:0] RING_ADDR,
	output logic RING_WRITE,
	output logic RING_SNOOP,
	output logic RING_FAULT,
	input wire logic ACC_VALID,
	input wire logic [23:0] ACC_ADDR,
	input wire logic ACC_FUNC,
	input wire gmaf_pkg::gmaf_src_t ACC_SRC,
	input wire logic ACC_WRITE,
	input wire gmaf_pkg::gmaf_size_t ACC_SIZE,
	input wire logic [63:0] ACC_WDATA,
	output logic ACC_RVALID,
	output logic [63:0] ACC_RDATA,
	output logic ACC_ERR,
	input wire logic FUNC0_MEM_EN,
	input wire logic FUNC1_MEM_EN,
	input wire logic PWR_SAVE,
	output logic MC_VALID,
	output logic [`GMAF_ALIAS_OFS_W-1:0] MC_ADDR,
	output logic MC_WRITE,
	output gmaf_pkg::gmaf_size_t MC_SIZE,
	output logic [63:0] MC_WDATA,
	input wire logic MC_RVALID,
	input wire logic [63:0] MC_RDATA,
	output logic REG_VALID,
	output logic [23:0] REG_ADDR,
	output logic REG_WRITE,
	output gmaf_pkg::gmaf_size_t REG_SIZE,
	output logic [63:0] REG_WDATA,
	input wire logic REG_RVALID,
	input wire logic [63:0] REG_RDATA
);

	logic [CNT_W-1:0] max_cnt [N_REQ];
	logic [CNT_W-1:0] used [N_REQ];
	logic [N_REQ-1:0] exh;
	logic [N_REQ-1:0] next_gnt;
	gmaf_pkg::gmaf_grace_t grace;
	logic grace_done;
	logic restart;
	logic path_ready;
	logic arb_go;
	logic [AW-1:0] sel_addr;
	logic sel_write;
	logic sel_tiled;
	logic host_ok;

	// ---------------------------------------------
	// Maximum counts
	// ---------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < N_REQ; i++) begin
				max_cnt[i] <= `GMAF_MAX_TOP - CNT_W'(i) * `GMAF_MAX_STEP;
			end
		end else if (CFG_WE) begin
			max_cnt[CFG_IDX] <= CFG_MAX;
		end
	end

	// ---------------------------------------------
	// Per-requester counts
	// ---------------------------------------------
	for (genvar g = 0; g < N_REQ; g++) begin : g_cnt
		gmaf_req_counter #(.CNT_W(CNT_W)) u_cnt (
			.clk(REF_CLK),
			.rst_n(RST_N),
			.max_cnt(max_cnt[g]),
			.charge(GNT[g]),
			.restart(restart),
			.used(used[g]),
			.exhausted(exh[g])
		);
	end

	assign DEMOTED = exh;

	// ---------------------------------------------
	// Grace period
	// ---------------------------------------------
	// Idle requesters would never spend their counts, so the period also
	// ends once only demoted requesters are asking.
	assign grace_done = (&exh) || ((|(REQ & exh)) && !(|(REQ & ~exh)));
	assign restart = (grace == gmaf_pkg::GR_END);

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			grace <= gmaf_pkg::GR_IDLE;
		end else begin
			case (grace)
				gmaf_pkg::GR_IDLE: begin
					if (|GNT) begin
						grace <= gmaf_pkg::GR_RUN;
					end
				end
				gmaf_pkg::GR_RUN: begin
					if (grace_done) begin
						grace <= gmaf_pkg::GR_END;
					end
				end
				gmaf_pkg::GR_END: begin
					grace <= gmaf_pkg::GR_IDLE;
				end
				default: begin
					grace <= gmaf_pkg::GR_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// Arbitration
	// ---------------------------------------------
	assign host_ok = HOST_VALID && !(HOST_PEER && !HOST_WRITE);
	assign arb_go = path_ready && !host_ok;

	always_comb begin
		logic found;
		found = 1'b0;
		next_gnt = '0;
		for (int lv = `GMAF_LEVELS - 1; lv >= 0; lv--) begin
			for (int i = 0; i < N_REQ; i++) begin
				if (!found && REQ[i] && !exh[i] && REQ_LEVEL[2*i +: 2] == 2'(lv)) begin
					next_gnt[i] = 1'b1;
					found = 1'b1;
				end
			end
		end
		for (int i = 0; i < N_REQ; i++) begin
			if (!found && REQ[i] && exh[i]) begin
				next_gnt[i] = 1'b1;
				found = 1'b1;
			end
		end
	end

	assign GNT = arb_go ? next_gnt : '0;

	always_comb begin
		sel_addr = HOST_ADDR;
		sel_write = HOST_WRITE;
		sel_tiled = 1'b0;
		for (int i = 0; i < N_REQ; i++) begin
			if (GNT[i]) begin
				sel_addr = REQ_ADDR[i*AW +: AW];
				sel_write = REQ_WRITE[i];
				sel_tiled = REQ_TILED[i];
			end
		end
	end

	// Peer reads are refused, peer writes take the translated path
	assign HOST_READY = path_ready;
	assign HOST_ERR = HOST_VALID && HOST_PEER && !HOST_WRITE;

	// ---------------------------------------------
	// Address path
	// ---------------------------------------------
	gmaf_addr_path #(.AW(AW), .PA_W(PA_W), .IDX_W(IDX_W)) u_path (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.in_valid(host_ok || (|GNT)),
		.in_ready(path_ready),
		.in_addr(sel_addr),
		.in_write(sel_write),
		.in_cpu(host_ok && !HOST_PEER),
		.in_surf_tiled(sel_tiled),
		.gm_base(GM_BASE),
		.fence_lo(FENCE_LO),
		.fence_hi(FENCE_HI),
		.fence_pitch_log2(FENCE_PITCH_LOG2),
		.pte_we(PTE_WE),
		.pte_idx(PTE_IDX),
		.pte_frame(PTE_FRAME),
		.pte_cacheable(PTE_CACHEABLE),
		.out_valid(RING_VALID),
		.out_ready(RING_READY),
		.out_addr(RING_ADDR),
		.out_write(RING_WRITE),
		.out_snoop(RING_SNOOP),
		.out_fault(RING_FAULT)
	);

	// ---------------------------------------------
	// Register access and alias window
	// ---------------------------------------------
	logic win_hit;
	logic aligned;
	logic alias_on;
	logic is_cpu;

	assign win_hit = ACC_ADDR >= `GMAF_ALIAS_FIRST && ACC_ADDR <= `GMAF_ALIAS_LAST;
	assign aligned = ACC_SIZE != gmaf_pkg::SZ_BYTE
		&& (ACC_ADDR & ((24'h1 << ACC_SIZE) - 24'h1)) == 24'h0;
	assign alias_on = (ACC_FUNC ? FUNC1_MEM_EN : FUNC0_MEM_EN) && !PWR_SAVE;
	assign is_cpu = ACC_SRC == gmaf_pkg::SRC_CPU;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MC_VALID <= 1'b0;
			MC_ADDR <= '0;
			MC_WRITE <= 1'b0;
			MC_SIZE <= gmaf_pkg::SZ_WORD;
			MC_WDATA <= '0;
		end else begin
			MC_VALID <= ACC_VALID && win_hit && aligned && alias_on && is_cpu;
			MC_ADDR <= ACC_ADDR[`GMAF_ALIAS_OFS_W-1:0];
			MC_WRITE <= ACC_WRITE;
			MC_SIZE <= ACC_SIZE;
			MC_WDATA <= ACC_WDATA;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_VALID <= 1'b0;
			REG_ADDR <= '0;
			REG_WRITE <= 1'b0;
			REG_SIZE <= gmaf_pkg::SZ_WORD;
			REG_WDATA <= '0;
		end else begin
			REG_VALID <= ACC_VALID && !win_hit && alias_on
				&& ACC_SRC != gmaf_pkg::SRC_PEER;
			REG_ADDR <= ACC_ADDR;
			REG_WRITE <= ACC_WRITE;
			REG_SIZE <= ACC_SIZE;
			REG_WDATA <= ACC_WDATA;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ACC_RVALID <= 1'b0;
			ACC_RDATA <= '0;
			ACC_ERR <= 1'b0;
		end else begin
			ACC_ERR <= ACC_VALID && (ACC_SRC == gmaf_pkg::SRC_PEER || !alias_on
				|| (win_hit && is_cpu && !aligned));
			if (ACC_VALID && win_hit && alias_on && ACC_SRC == gmaf_pkg::SRC_SRM
				&& !ACC_WRITE) begin
				ACC_RVALID <= 1'b1;
				ACC_RDATA <= '0;
			end else if (MC_RVALID) begin
				ACC_RVALID <= 1'b1;
				ACC_RDATA <= MC_RDATA;
			end else begin
				ACC_RVALID <= REG_RVALID;
				ACC_RDATA <= REG_RDATA;
			end
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	a_gnt_onehot: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$onehot0(GNT) && (GNT & ~REQ) == '0) else $error("bad grant vector");

	a_demoted_last: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		|(GNT & exh) |-> !(|(REQ & ~exh))) else $error("demoted requester beat a live one");

	a_grace_ends: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		grace == gmaf_pkg::GR_RUN && (&exh) |=> restart ##1 grace == gmaf_pkg::GR_IDLE)
		else $error("grace period did not end");

	a_alias_fwd: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID && win_hit && aligned && alias_on && is_cpu
		|=> MC_VALID && MC_ADDR == $past(ACC_ADDR[`GMAF_ALIAS_OFS_W-1:0])
		&& MC_SIZE == $past(ACC_SIZE)) else $error("alias access not forwarded");

	a_lri_dropped: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID && win_hit && ACC_SRC == gmaf_pkg::SRC_LRI |=> !MC_VALID && !REG_VALID)
		else $error("command load reached alias");

	a_srm_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID && win_hit && alias_on && ACC_SRC == gmaf_pkg::SRC_SRM && !ACC_WRITE
		|=> ACC_RVALID && ACC_RDATA == 64'h0) else $error("command store read not zero");

	a_alias_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID && (PWR_SAVE || !(ACC_FUNC ? FUNC1_MEM_EN : FUNC0_MEM_EN))
		|=> !MC_VALID && ACC_ERR) else $error("alias active while disabled");

	a_peer_refused: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		ACC_VALID && ACC_SRC == gmaf_pkg::SRC_PEER |=> ACC_ERR && !MC_VALID && !REG_VALID)
		else $error("peer register access accepted");

endmodule

// >>> verification/gmaf_far_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Far side: ring sink and register targets
// ----------------------------------------
module gmaf_far_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mc_valid,
	input wire logic [14:0] mc_addr,
	input wire logic mc_write,
	output logic mc_rvalid,
	output logic [63:0] mc_rdata,
	input wire logic reg_valid,
	input wire logic [23:0] reg_addr,
	input wire logic reg_write,
	output logic reg_rvalid,
	output logic [63:0] reg_rdata,
	output logic ring_ready
);
	// Read data after one cycle, flipped bus while idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mc_rvalid <= 1'b0;
			mc_rdata <= 64'h0;
			reg_rvalid <= 1'b0;
			reg_rdata <= 64'h0;
		end else begin
			mc_rvalid <= mc_valid & ~mc_write;
			reg_rvalid <= reg_valid & ~reg_write;
			if (mc_valid & ~mc_write) begin
				mc_rdata <= {49'h0, mc_addr} ^ 64'hC0DE_0000_0000_0000;
			end else begin
				mc_rdata <= ~mc_rdata;
			end
			if (reg_valid & ~reg_write) begin
				reg_rdata <= {40'h0, reg_addr} ^ 64'h5A5A_0000_0000_0000;
			end else begin
				reg_rdata <= ~reg_rdata;
			end
		end
	end

	// Ring accepts every cycle, or every other cycle when slow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_ready <= 1'b1;
		end else begin
			ring_ready <= slow ? ~ring_ready : 1'b1;
		end
	end
endmodule

// >>> verification/gmaf_top_test.sv
`timescale 1ns/1ns
module gmaf_top_test;
	logic clk, rst_n, cfg_we, host_valid, host_write, host_peer, pte_we, pte_cacheable;
	logic acc_valid, acc_func, acc_write, f0_en, f1_en, pwr_save, slow;
	logic [3:0] req, req_write, req_tiled, gnt, demoted;
	logic [127:0] req_addr;
	logic [7:0] req_level, cfg_max;
	logic [1:0] cfg_idx;
	logic [31:0] host_addr, gm_base, fence_lo, fence_hi;
	logic [2:0] fence_pitch;
	logic [5:0] pte_idx;
	logic [26:0] pte_frame;
	logic [23:0] acc_addr, reg_addr;
	gmaf_pkg::gmaf_src_t acc_src;
	gmaf_pkg::gmaf_size_t acc_size, mc_size, reg_size;
	logic [63:0] acc_wdata, acc_rdata, mc_wdata, mc_rdata, reg_wdata, reg_rdata;
	logic host_ready, host_err, ring_valid, ring_ready, ring_write, ring_snoop, ring_fault;
	logic [38:0] ring_addr;
	logic acc_rvalid, acc_err, mc_valid, mc_write, mc_rvalid, reg_valid, reg_write, reg_rvalid;
	logic [14:0] mc_addr;
	int error_cnt, checked;

	gmaf_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .REQ(req), .REQ_ADDR(req_addr),
		.REQ_WRITE(req_write), .REQ_TILED(req_tiled), .REQ_LEVEL(req_level), .GNT(gnt),
		.CFG_WE(cfg_we), .CFG_IDX(cfg_idx), .CFG_MAX(cfg_max), .DEMOTED(demoted),
		.HOST_VALID(host_valid), .HOST_READY(host_ready), .HOST_ADDR(host_addr),
		.HOST_WRITE(host_write), .HOST_PEER(host_peer), .HOST_ERR(host_err),
		.GM_BASE(gm_base), .FENCE_LO(fence_lo), .FENCE_HI(fence_hi),
		.FENCE_PITCH_LOG2(fence_pitch), .PTE_WE(pte_we), .PTE_IDX(pte_idx),
		.PTE_FRAME(pte_frame), .PTE_CACHEABLE(pte_cacheable), .RING_VALID(ring_valid),
		.RING_READY(ring_ready), .RING_ADDR(ring_addr), .RING_WRITE(ring_write),
		.RING_SNOOP(ring_snoop), .RING_FAULT(ring_fault), .ACC_VALID(acc_valid),
		.ACC_ADDR(acc_addr), .ACC_FUNC(acc_func), .ACC_SRC(acc_src), .ACC_WRITE(acc_write),
		.ACC_SIZE(acc_size), .ACC_WDATA(acc_wdata), .ACC_RVALID(acc_rvalid),
		.ACC_RDATA(acc_rdata), .ACC_ERR(acc_err), .FUNC0_MEM_EN(f0_en), .FUNC1_MEM_EN(f1_en),
		.PWR_SAVE(pwr_save), .MC_VALID(mc_valid), .MC_ADDR(mc_addr), .MC_WRITE(mc_write),
		.MC_SIZE(mc_size), .MC_WDATA(mc_wdata), .MC_RVALID(mc_rvalid), .MC_RDATA(mc_rdata),
		.REG_VALID(reg_valid), .REG_ADDR(reg_addr), .REG_WRITE(reg_write),
		.REG_SIZE(reg_size), .REG_WDATA(reg_wdata), .REG_RVALID(reg_rvalid),
		.REG_RDATA(reg_rdata));

	gmaf_far_model i_far (.clk(clk), .rst_n(rst_n), .slow(slow), .mc_valid(mc_valid),
		.mc_addr(mc_addr), .mc_write(mc_write), .mc_rvalid(mc_rvalid), .mc_rdata(mc_rdata),
		.reg_valid(reg_valid), .reg_addr(reg_addr), .reg_write(reg_write),
		.reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .ring_ready(ring_ready));

	always #5 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task do_reset;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
	endtask

	task grant(input int idx, input int n);
		int k;
		k = 0;
		req = 4'h1 << idx;
		for (int t = 0; t < 20 && k < n; t++) begin
			#1;
			if (gnt[idx] === 1'b1) k++;
			@(negedge clk);
		end
		req = 4'h0;
		@(negedge clk);
		chk("grant_cnt", n, k);
	endtask

	task host(input logic [31:0] a, input logic w, input logic p);
		int t;
		t = 0;
		@(negedge clk);
		host_addr = a;
		host_write = w;
		host_peer = p;
		host_valid = 1'b1;
		#1;
		while (host_ready !== 1'b1 && t < 20) begin
			@(negedge clk);
			#1;
			t++;
		end
		@(negedge clk);
		host_valid = 1'b0;
		chk("ring_valid", 1, ring_valid);
	endtask

	// Expected outcome bits: forwarded to alias, to registers, error, read data
	task acc(input gmaf_pkg::gmaf_src_t s, input logic f, input logic [23:0] a,
		input logic w, input gmaf_pkg::gmaf_size_t z, input logic [3:0] exp);
		logic [3:0] seen;
		logic [63:0] d, wd, rd;
		logic [23:0] fa;
		logic fw;
		gmaf_pkg::gmaf_size_t fz;
		seen = 4'h0;
		acc_src = s;
		acc_func = f;
		acc_addr = a;
		acc_write = w;
		acc_size = z;
		acc_valid = 1'b1;
		@(negedge clk);
		acc_valid = 1'b0;
		repeat (6) begin
			if (mc_valid === 1'b1) begin
				seen[3] = 1'b1;
				fa = {9'h0, mc_addr};
				fw = mc_write;
				fz = mc_size;
				wd = mc_wdata;
			end
			if (reg_valid === 1'b1) begin
				seen[2] = 1'b1;
				fa = reg_addr;
				fw = reg_write;
				fz = reg_size;
				wd = reg_wdata;
			end
			if (acc_err === 1'b1) seen[1] = 1'b1;
			if (acc_rvalid === 1'b1) begin
				seen[0] = 1'b1;
				d = acc_rdata;
			end
			@(negedge clk);
		end
		chk("acc_path", exp, seen);
		if (exp[3] | exp[2]) begin
			chk("fwd_addr", exp[3] ? {9'h0, a[14:0]} : a, fa);
			chk("fwd_write", w, fw);
			chk("fwd_size", z, fz);
		end
		if ((exp[3] | exp[2]) & w) chk("fwd_wdata", acc_wdata, wd);
		rd = exp[3] ? ({49'h0, a[14:0]} ^ 64'hC0DE_0000_0000_0000) : 64'h0;
		if (exp[2]) rd = {40'h0, a} ^ 64'h5A5A_0000_0000_0000;
		if (exp[0]) chk("rdata", rd, d);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task test_prio;
		do_reset();
		req = 4'hF;
		for (int i = 0; i < 4; i++) begin
			req_level = 8'h00;
			req_level[2*i+:2] = 2'h3;
			#1;
			chk("gnt_level", 4'h1 << i, gnt);
			@(negedge clk);
		end
		req_level = 8'h55;
		#1;
		chk("gnt_order", 4'h1, gnt);
		@(negedge clk);
		req = 4'h0;
		$display("test_prio done");
	endtask

	task test_demote;
		do_reset();
		cfg_idx = 2'h0;
		cfg_max = 8'h02;
		cfg_we = 1'b1;
		@(negedge clk);
		cfg_we = 1'b0;
		req_level = 8'h00;
		grant(3, 3);
		chk("demoted", 4'h0, demoted);
		grant(3, 1);
		chk("demoted", 4'h8, demoted);
		grant(0, 2);
		chk("demoted", 4'h9, demoted);
		req_level = 8'hC0;
		req = 4'hC;
		#1;
		chk("gnt_demoted", 4'h4, gnt);
		@(negedge clk);
		req = 4'h8;
		repeat (4) @(negedge clk);
		req = 4'h0;
		chk("grace_restart", 4'h0, demoted);
		$display("test_demote done");
	endtask

	task test_expire;
		do_reset();
		req_level = 8'h00;
		cfg_max = 8'h01;
		cfg_we = 1'b1;
		for (int i = 0; i < 4; i++) begin
			cfg_idx = 2'(i);
			@(negedge clk);
		end
		cfg_we = 1'b0;
		req = 4'hF;
		repeat (4) @(negedge clk);
		req = 4'h0;
		chk("all_spent", 4'hF, demoted);
		repeat (2) @(negedge clk);
		chk("all_restart", 4'h0, demoted);
		$display("test_expire done");
	endtask

	task test_host;
		do_reset();
		gm_base = 32'h1000_0000;
		pte_idx = 6'h05;
		pte_frame = 27'h0ABCDE1;
		pte_cacheable = 1'b1;
		pte_we = 1'b1;
		@(negedge clk);
		pte_we = 1'b0;
		slow = 1'b1;
		host(32'h1000_5345, 1'b0, 1'b0);
		chk("ring_addr", {27'h0ABCDE1, 12'h345}, ring_addr);
		chk("ring_snoop", 1, ring_snoop);
		chk("ring_fault", 0, ring_fault);
		fence_lo = 32'h0;
		fence_hi = 32'h0000_FFFF;
		host(32'h1000_3A45, 1'b0, 1'b0);
		chk("tiled_addr", {27'h0ABCDE1, 12'h645}, ring_addr);
		fence_lo = 32'hFFFF_FFFF;
		host(32'h1000_5008, 1'b1, 1'b1);
		chk("peer_snoop", 0, ring_snoop);
		chk("peer_write", 1, ring_write);
		host(32'h1000_7000, 1'b0, 1'b0);
		chk("ring_fault", 1, ring_fault);
		repeat (4) @(negedge clk);
		host_peer = 1'b1;
		host_write = 1'b0;
		host_valid = 1'b1;
		#1;
		chk("host_err", 1, host_err);
		repeat (3) @(negedge clk);
		host_valid = 1'b0;
		chk("peer_read", 0, ring_valid);
		slow = 1'b0;
		$display("test_host done");
	endtask

	task test_alias;
		do_reset();
		acc(gmaf_pkg::SRC_CPU, 0, 24'h140010, 0, gmaf_pkg::SZ_DWORD, 4'h9);
		acc(gmaf_pkg::SRC_CPU, 1, 24'h147FF8, 1, gmaf_pkg::SZ_QWORD, 4'h8);
		acc(gmaf_pkg::SRC_CPU, 0, 24'h147FFE, 0, gmaf_pkg::SZ_WORD, 4'h9);
		acc(gmaf_pkg::SRC_CPU, 0, 24'h140000, 0, gmaf_pkg::SZ_BYTE, 4'h2);
		acc(gmaf_pkg::SRC_CPU, 0, 24'h140002, 1, gmaf_pkg::SZ_DWORD, 4'h2);
		acc(gmaf_pkg::SRC_CPU, 0, 24'h148000, 0, gmaf_pkg::SZ_DWORD, 4'h5);
		acc(gmaf_pkg::SRC_LRI, 0, 24'h140010, 1, gmaf_pkg::SZ_DWORD, 4'h0);
		acc(gmaf_pkg::SRC_SRM, 0, 24'h140010, 0, gmaf_pkg::SZ_DWORD, 4'h1);
		acc(gmaf_pkg::SRC_PEER, 0, 24'h000100, 0, gmaf_pkg::SZ_DWORD, 4'h2);
		acc(gmaf_pkg::SRC_CPU, 1, 24'h000100, 0, gmaf_pkg::SZ_DWORD, 4'h5);
		acc(gmaf_pkg::SRC_CPU, 0, 24'h000200, 1, gmaf_pkg::SZ_DWORD, 4'h4);
		f1_en = 1'b0;
		acc(gmaf_pkg::SRC_CPU, 1, 24'h140010, 0, gmaf_pkg::SZ_DWORD, 4'h2);
		f1_en = 1'b1;
		pwr_save = 1'b1;
		acc(gmaf_pkg::SRC_CPU, 0, 24'h140010, 1, gmaf_pkg::SZ_DWORD, 4'h2);
		pwr_save = 1'b0;
		$display("test_alias done");
	endtask

	task finish_test;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{cfg_we, host_valid, host_write, host_peer, pte_we, pte_cacheable} = 6'h00;
		{acc_valid, acc_func, acc_write, pwr_save, slow} = 5'h00;
		{f0_en, f1_en} = 2'h3;
		req = 4'h0;
		req_write = 4'h5;
		req_tiled = 4'h2;
		req_addr = {32'h1000_3000, 32'h1000_2000, 32'h1000_1000, 32'h1000_0000};
		{req_level, cfg_max, cfg_idx} = 18'h0;
		{host_addr, gm_base, fence_hi} = 96'h0;
		fence_lo = 32'hFFFF_FFFF;
		fence_pitch = 3'h3;
		{pte_idx, pte_frame} = 33'h0;
		acc_addr = 24'h0;
		acc_src = gmaf_pkg::SRC_CPU;
		acc_size = gmaf_pkg::SZ_DWORD;
		acc_wdata = 64'h1122_3344_5566_7788;
		error_cnt = 0;
		checked = 0;
		@(negedge clk);
		test_prio();
		test_demote();
		test_expire();
		test_host();
		test_alias();
		finish_test();
	end

	initial begin
		#20000;
		error_cnt++;
		finish_test();
	end
endmodule
